// ### rtl/gauge_pkg.sv
package gauge_pkg;
	// ----------------------------------------
	// Host function codes
	// ----------------------------------------
	localparam logic [7:0] CMD_STATUS = 8'h16;
	localparam logic [7:0] CMD_CYCLE = 8'h17;
	localparam logic [7:0] CMD_CAPACITY = 8'h18;
	localparam logic [7:0] CMD_VOLTAGE = 8'h19;
	localparam logic [7:0] CMD_DEF_LAST = 8'h23;

	// ----------------------------------------
	// Configuration memory locations (low byte first)
	// ----------------------------------------
	localparam logic [7:0] CFG_CYCLE_LO = 8'h0e;
	localparam logic [7:0] CFG_CYCLE_HI = 8'h0f;
	localparam logic [7:0] CFG_VOLTAGE = 8'h12;
	localparam logic [7:0] CFG_CYC_THR = 8'h3c;
	localparam logic [7:0] CFG_FULL_CLR = 8'h4c;
	localparam logic [7:0] CFG_CAP_MAH = 8'h08;
	localparam logic [7:0] CFG_CAP_MWH = 8'h0a;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	// ----------------------------------------
	// Status word layout
	// ----------------------------------------
	localparam int BIT_OVER_TEMP = 12;
	localparam int BIT_STOP_DIS = 11;
	localparam int BIT_CAP_AL = 9;
	localparam int BIT_TIME_AL = 8;
	localparam int BIT_LOADED = 7;
	localparam int BIT_DISCH = 6;
	localparam int BIT_FULL = 5;
	localparam int BIT_EMPTY = 4;
	localparam logic FLAG_RESET = 1'b0;

	// ----------------------------------------
	// Error codes, status bits 3:0
	// ----------------------------------------
	localparam logic [3:0] ERR_OK = 4'h0;
	localparam logic [3:0] ERR_BUSY = 4'h1;
	localparam logic [3:0] ERR_RESERVED = 4'h2;
	localparam logic [3:0] ERR_UNSUPPORTED = 4'h3;
	localparam logic [3:0] ERR_DENIED = 4'h4;
	localparam logic [3:0] ERR_OVERFLOW = 4'h5;
	localparam logic [3:0] ERR_BAD_SIZE = 4'h6;
	localparam logic [3:0] ERR_UNKNOWN = 4'h7;
	localparam logic [3:0] ERR_ALL_ONES = 4'hf;

	// ----------------------------------------
	// Thresholds and timing
	// ----------------------------------------
	localparam logic [15:0] FILTER_WINDOW = 16'd22500;
	localparam logic [7:0] EMPTY_CLR_PCT = 8'd20;
	localparam logic [15:0] CYCLE_SAT = 16'hffff;
	localparam int CLK_NS = 50;
	localparam int SECOND_NS = 1000000000;
	localparam int SECOND_CYCLES = SECOND_NS / CLK_NS;

	typedef enum logic [1:0] {WB_IDLE, WB_HIGH, WB_SPARE} wb_state_t;

	// Merge one loaded config byte into a little-endian word
	function automatic logic [15:0] put_byte(input logic [15:0] w,
		input logic [7:0] a, input logic [7:0] base,
		input logic [7:0] d);
		logic [15:0] r;
		r = w;
		if (a == base) r[7:0] = d;
		if (a == base + 8'h01) r[15:8] = d;
		return r;
	endfunction
endpackage

// ### rtl/second_tick.sv
`timescale 1ns/1ns
// One-cycle enable once per second of system clock
module second_tick import gauge_pkg::*; #(
	parameter int PERIOD = SECOND_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	output logic tick
);
	logic [24:0] cnt;
	logic [24:0] next_cnt;
	logic next_tick;

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	always_comb begin
		next_tick = (cnt == 25'(PERIOD - 1));
		next_cnt = next_tick ? 25'h0000000 : cnt + 25'h0000001;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt <= 25'h0000000;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule

// ### rtl/cycle_count_unit.sv
`timescale 1ns/1ns
// Saturating cycle counter, loadable byte by byte from config memory
module cycle_count_unit import gauge_pkg::*; (
	input wire logic mclk,
	input wire logic srst,
	input wire logic load_lo,
	input wire logic load_hi,
	input wire logic [7:0] load_data,
	input wire logic inc,
	output logic [15:0] count,
	output logic updated
);
	logic [15:0] next_count;
	logic next_updated;

	// ----------------------------------------
	// Count; a load is not an update, so it is not written back
	// ----------------------------------------
	always_comb begin
		next_count = count;
		next_updated = 1'b0;
		if (load_lo) next_count[7:0] = load_data;
		if (load_hi) next_count[15:8] = load_data;
		if (inc && count != CYCLE_SAT) begin
			next_count = count + 16'h0001;
			next_updated = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			count <= CFG_RESET;
			updated <= 1'b0;
		end else begin
			count <= next_count;
			updated <= next_updated;
		end
	end
endmodule

// ### rtl/battery_status_flag_logic.sv
`timescale 1ns/1ns
// Operation
// - Over-temperature alarm follows temperature at or above the limit.
// - Stop-discharge alarm sets on zero capacity, low voltage or cell fault.
// - Stop-discharge alarm clears only when all three causes are gone.
// - Capacity alarm sets when remaining capacity is below its threshold.
// - Capacity alarm clears on lower threshold or capacity rising by charge.
// - Time alarm sets when present-rate runtime is below its threshold.
// - Time alarm clears on lower threshold or averaged runtime rising by charge.
// - Load-valid flag sets on good config load, clears on bad one.
// - Discharging sets on discharge or long charge silence; clears charging.
// - Fully-charged sets on termination or overcharge; clears at low charge.
// - Fully-discharged sets on low voltage at light load or low charge.
// - Fully-discharged clears only at twenty percent charge or more.
// - OK code after clean access, busy code when not ready, except for accesses to the status function.
// - Reserved code for reserved functions, unsupported for defined ones.
// - Access-denied code for writes to read-only functions.
// - Bad-size, overflow and unknown codes for those error cases.
// - Function 0x17 reads the 16-bit cycle count.
// - Cycle count written back to config after every update.
// - Cycle count saturates at its maximum value.
// - Function 0x18 reads capacity in units chosen by capacity mode.
// - Function 0x19 reads nominal voltage from config.
// - Alarm broadcast word has all error-code bits set.
module battery_status_flag_logic import gauge_pkg::*; #(
	parameter int TICK_CYCLES = SECOND_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [15:0] temperature,
	input wire logic [15:0] max_temperature_limit,
	input wire logic [15:0] remaining_capacity_value,
	input wire logic [15:0] pack_voltage,
	input wire logic [15:0] cell_voltage,
	input wire logic [15:0] final_empty_voltage_threshold,
	input wire logic [15:0] early_empty_voltage_threshold,
	input wire logic cell_undervoltage_flag,
	input wire logic [15:0] capacity_alarm_threshold,
	input wire logic [15:0] time_alarm_threshold,
	input wire logic [15:0] runtime_estimate,
	input wire logic [15:0] averaged_runtime_estimate,
	input wire logic [15:0] discharge_current,
	input wire logic [15:0] overload_current_limit,
	input wire logic [7:0] charge_percentage,
	input wire logic [7:0] battery_low_pct,
	input wire logic [7:0] activity_filter_setting,
	input wire logic charging,
	input wire logic charge_activity,
	input wire logic discharge_activity,
	input wire logic charge_termination,
	input wire logic overcharge,
	input wire logic discharged_unit,
	input wire logic capacity_mode,
	input wire logic cfg_load_valid,
	input wire logic [7:0] cfg_load_addr,
	input wire logic [7:0] cfg_load_data,
	input wire logic cfg_load_ok,
	input wire logic cfg_load_bad,
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic [7:0] acc_code,
	input wire logic acc_bad_size,
	input wire logic acc_overflow,
	input wire logic acc_unknown,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic [15:0] status_word,
	output logic [15:0] alarm_word,
	output logic cfg_wr_valid,
	output logic [7:0] cfg_wr_addr,
	output logic [7:0] cfg_wr_data
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic over_temp, stop_dis, cap_al, time_al;
	logic loaded, disch, full, empty;
	logic [3:0] err, next_err;
	logic [15:0] prev_rm, prev_avg, quiet_acc, dis_acc, cyc_count;
	logic [15:0] cap_mah, cap_mwh, volt_cfg, cyc_thr, clr_word;
	wb_state_t wb_state, next_wb_state;
	logic next_over_temp, next_stop_dis, next_cap_al, next_time_al;
	logic next_loaded, next_disch, next_full, next_empty;
	logic [15:0] next_quiet_acc, next_dis_acc, next_status, next_rsp_data;
	logic [15:0] next_cap_mah, next_cap_mwh, next_volt_cfg;
	logic [15:0] next_cyc_thr, next_clr_word;
	logic next_rsp_valid, next_wr_valid;
	logic [7:0] next_wr_addr, next_wr_data;
	logic tick, cyc_inc, cyc_updated, quiet_done, busy;

	second_tick #(.PERIOD(TICK_CYCLES)) u_tick (
		.mclk(mclk),
		.srst(srst),
		.tick(tick)
	);

	cycle_count_unit u_cycles (
		.mclk(mclk),
		.srst(srst),
		.load_lo(cfg_load_valid && cfg_load_addr == CFG_CYCLE_LO),
		.load_hi(cfg_load_valid && cfg_load_addr == CFG_CYCLE_HI),
		.load_data(cfg_load_data),
		.inc(cyc_inc),
		.count(cyc_count),
		.updated(cyc_updated)
	);

	// ----------------------------------------
	// Config shadow words, captured as the image streams in
	// ----------------------------------------
	always_comb begin
		next_cap_mah = cap_mah;
		next_cap_mwh = cap_mwh;
		next_volt_cfg = volt_cfg;
		next_cyc_thr = cyc_thr;
		next_clr_word = clr_word;
		if (cfg_load_valid) begin
			next_cap_mah = put_byte(cap_mah, cfg_load_addr, CFG_CAP_MAH,
				cfg_load_data);
			next_cap_mwh = put_byte(cap_mwh, cfg_load_addr, CFG_CAP_MWH,
				cfg_load_data);
			next_volt_cfg = put_byte(volt_cfg, cfg_load_addr, CFG_VOLTAGE,
				cfg_load_data);
			next_cyc_thr = put_byte(cyc_thr, cfg_load_addr, CFG_CYC_THR,
				cfg_load_data);
			next_clr_word = put_byte(clr_word, cfg_load_addr, CFG_FULL_CLR,
				cfg_load_data);
		end
	end

	// ----------------------------------------
	// Activity timers
	// ----------------------------------------
	// Adding the filter value each second avoids a hardware divider:
	// the window closes after 22500/filter seconds.
	assign quiet_done = quiet_acc >= FILTER_WINDOW;
	assign cyc_inc = discharged_unit && cyc_thr != CFG_RESET &&
		dis_acc + 16'h0001 >= cyc_thr;
	always_comb begin
		next_quiet_acc = quiet_acc;
		if (charge_activity)
			next_quiet_acc = CFG_RESET;
		else if (tick && !quiet_done)
			next_quiet_acc = quiet_acc + {8'h00, activity_filter_setting};
		next_dis_acc = dis_acc;
		if (cyc_inc)
			next_dis_acc = CFG_RESET;
		else if (discharged_unit)
			next_dis_acc = dis_acc + 16'h0001;
	end

	// ----------------------------------------
	// Alarm and status flags; a set beats a clear in the same cycle
	// ----------------------------------------
	always_comb begin
		next_over_temp = temperature >= max_temperature_limit;
		// Set and clear terms are exact complements, so a level suffices
		next_stop_dis = remaining_capacity_value == 16'h0000 ||
			pack_voltage <= final_empty_voltage_threshold ||
			cell_undervoltage_flag;
		next_cap_al = (remaining_capacity_value < capacity_alarm_threshold)
			|| (cap_al && !(capacity_alarm_threshold <
			remaining_capacity_value || (charging &&
			remaining_capacity_value > prev_rm)));
		next_time_al = (runtime_estimate < time_alarm_threshold) ||
			(time_al && !(time_alarm_threshold < averaged_runtime_estimate
			|| (charging && averaged_runtime_estimate > prev_avg)));
		next_loaded = cfg_load_ok || (loaded && !cfg_load_bad);
		next_disch = discharge_activity || quiet_done ||
			(disch && !charging);
		next_full = charge_termination || overcharge ||
			(full && charge_percentage > clr_word[7:0]);
		next_empty = (((pack_voltage < early_empty_voltage_threshold) ||
			(cell_voltage < early_empty_voltage_threshold)) &&
			discharge_current < overload_current_limit) ||
			charge_percentage < battery_low_pct ||
			(empty && charge_percentage < EMPTY_CLR_PCT);
	end

	// ----------------------------------------
	// Host access: error code and read data
	// ----------------------------------------
	assign busy = wb_state != WB_IDLE;
	always_comb begin
		next_err = err;
		next_rsp_valid = acc_valid;
		next_rsp_data = 16'h0000;
		if (acc_valid) begin
			// Order: class of code, then readiness, then data errors
			if (acc_code > CMD_DEF_LAST)
				next_err = ERR_RESERVED;
			else if (acc_code < CMD_STATUS || acc_code > CMD_VOLTAGE)
				next_err = ERR_UNSUPPORTED;
			else if (busy && acc_code != CMD_STATUS)
				next_err = ERR_BUSY;
			else if (acc_write && acc_bad_size)
				next_err = ERR_BAD_SIZE;
			else if (acc_write)
				next_err = ERR_DENIED;
			else if (acc_overflow)
				next_err = ERR_OVERFLOW;
			else if (acc_unknown)
				next_err = ERR_UNKNOWN;
			else
				next_err = ERR_OK;
			if (next_err == ERR_OK) begin
				case (acc_code)
					CMD_STATUS: next_rsp_data = status_word;
					CMD_CYCLE: next_rsp_data = cyc_count;
					CMD_CAPACITY: next_rsp_data = capacity_mode ?
						cap_mwh : cap_mah;
					CMD_VOLTAGE: next_rsp_data = volt_cfg;
					default: next_rsp_data = 16'h0000;
				endcase
			end
		end
		next_status = 16'h0000;
		next_status[BIT_OVER_TEMP] = next_over_temp;
		next_status[BIT_STOP_DIS] = next_stop_dis;
		next_status[BIT_CAP_AL] = next_cap_al;
		next_status[BIT_TIME_AL] = next_time_al;
		next_status[BIT_LOADED] = next_loaded;
		next_status[BIT_DISCH] = next_disch;
		next_status[BIT_FULL] = next_full;
		next_status[BIT_EMPTY] = next_empty;
		next_status[3:0] = next_err;
	end

	// ----------------------------------------
	// Cycle count write-back: low byte, then high byte
	// ----------------------------------------
	// A new update during the high byte restarts the pair, so the
	// stored copy always ends on the latest count.
	always_comb begin
		next_wb_state = wb_state;
		next_wr_valid = 1'b0;
		next_wr_addr = cfg_wr_addr;
		next_wr_data = cfg_wr_data;
		case (wb_state)
			WB_IDLE, WB_HIGH: begin
				if (cyc_updated) begin
					next_wb_state = WB_HIGH;
					next_wr_valid = 1'b1;
					next_wr_addr = CFG_CYCLE_LO;
					next_wr_data = cyc_count[7:0];
				end else if (wb_state == WB_HIGH) begin
					next_wb_state = WB_IDLE;
					next_wr_valid = 1'b1;
					next_wr_addr = CFG_CYCLE_HI;
					next_wr_data = cyc_count[15:8];
				end
			end
			default: next_wb_state = WB_IDLE;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			{over_temp, stop_dis, cap_al, time_al} <= {4{FLAG_RESET}};
			{loaded, disch, full, empty} <= {4{FLAG_RESET}};
			err <= ERR_OK;
			{prev_rm, prev_avg, quiet_acc, dis_acc} <= {4{CFG_RESET}};
			{cap_mah, cap_mwh, volt_cfg, cyc_thr, clr_word} <= {5{CFG_RESET}};
			status_word <= 16'h0000;
			alarm_word <= {12'h000, ERR_ALL_ONES};
			{rsp_valid, rsp_data} <= 17'h00000;
			wb_state <= WB_IDLE;
			{cfg_wr_valid, cfg_wr_addr, cfg_wr_data} <= 17'h00000;
		end else begin
			{over_temp, stop_dis, cap_al, time_al} <= {next_over_temp,
				next_stop_dis, next_cap_al, next_time_al};
			{loaded, disch, full, empty} <= {next_loaded, next_disch,
				next_full, next_empty};
			err <= next_err;
			prev_rm <= remaining_capacity_value;
			prev_avg <= averaged_runtime_estimate;
			{quiet_acc, dis_acc} <= {next_quiet_acc, next_dis_acc};
			{cap_mah, cap_mwh, volt_cfg} <= {next_cap_mah, next_cap_mwh,
				next_volt_cfg};
			{cyc_thr, clr_word} <= {next_cyc_thr, next_clr_word};
			status_word <= next_status;
			alarm_word <= {next_status[15:4], ERR_ALL_ONES};
			{rsp_valid, rsp_data} <= {next_rsp_valid, next_rsp_data};
			wb_state <= next_wb_state;
			{cfg_wr_valid, cfg_wr_addr, cfg_wr_data} <= {next_wr_valid,
				next_wr_addr, next_wr_data};
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_wb_low;
		cfg_wr_valid && cfg_wr_addr == CFG_CYCLE_LO;
	endsequence
	sequence s_wb_high;
		cfg_wr_valid && cfg_wr_addr == CFG_CYCLE_HI;
	endsequence

	AST_OVER_TEMP: assert property (@(posedge mclk) disable iff (srst)
		temperature >= max_temperature_limit |=> status_word[BIT_OVER_TEMP])
		else $error("over-temperature flag missing");
	AST_STOP_SET: assert property (@(posedge mclk) disable iff (srst)
		remaining_capacity_value == 16'h0000 |=> status_word[BIT_STOP_DIS])
		else $error("stop-discharge flag not set");
	AST_STOP_CLR: assert property (@(posedge mclk) disable iff (srst)
		remaining_capacity_value != 16'h0000 && !cell_undervoltage_flag &&
		pack_voltage > final_empty_voltage_threshold
		|=> !status_word[BIT_STOP_DIS])
		else $error("stop-discharge flag not cleared");
	AST_CAP_SET: assert property (@(posedge mclk) disable iff (srst)
		remaining_capacity_value < capacity_alarm_threshold
		|=> status_word[BIT_CAP_AL] && cap_al)
		else $error("capacity alarm not set");
	AST_TIME_CLR: assert property (@(posedge mclk) disable iff (srst)
		runtime_estimate >= time_alarm_threshold &&
		time_alarm_threshold < averaged_runtime_estimate
		|=> !status_word[BIT_TIME_AL])
		else $error("time alarm not cleared");
	AST_EMPTY_HOLD: assert property (@(posedge mclk) disable iff (srst)
		empty && charge_percentage < EMPTY_CLR_PCT |=> empty)
		else $error("fully-discharged cleared early");
	AST_DENIED: assert property (@(posedge mclk) disable iff (srst)
		acc_valid && acc_write && !acc_bad_size && !busy &&
		acc_code >= CMD_STATUS && acc_code <= CMD_VOLTAGE
		|=> rsp_valid && status_word[3:0] == ERR_DENIED && rsp_data == 0)
		else $error("write to read-only not denied");
	AST_WRITEBACK: assert property (@(posedge mclk) disable iff (srst)
		cyc_updated ##1 !cyc_updated |-> s_wb_low ##1 s_wb_high)
		else $error("cycle count write-back sequence wrong");
	AST_ALARM_ONES: assert property (@(posedge mclk) disable iff (srst)
		##1 alarm_word == {status_word[15:4], ERR_ALL_ONES})
		else $error("alarm word differs from status word");
endmodule

// ### test/far_side_model.sv
`timescale 1ns/1ns
// Host and configuration memory facing the block
module far_side_model (
	input wire logic mclk,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic cfg_wr_valid,
	input wire logic [7:0] cfg_wr_addr,
	input wire logic [7:0] cfg_wr_data,
	output logic acc_valid = 1'b0,
	output logic acc_write = 1'b0,
	output logic [7:0] acc_code = 8'h00,
	output logic acc_bad_size = 1'b0,
	output logic acc_overflow = 1'b0,
	output logic acc_unknown = 1'b0,
	output logic cfg_load_valid = 1'b0,
	output logic [7:0] cfg_load_addr = 8'h00,
	output logic [7:0] cfg_load_data = 8'h00,
	output logic cfg_load_ok = 1'b0,
	output logic cfg_load_bad = 1'b0
);
	// Memory starts blank so a missing write-back shows
	logic [7:0] mem [256] = '{default: 8'h00};
	logic got_valid;
	logic [15:0] got_data;

	// -----------------------------
	// Configuration memory write port
	// -----------------------------
	always @(posedge mclk) begin
		if (cfg_wr_valid) begin
			mem[cfg_wr_addr] <= cfg_wr_data;
		end
	end

	// One access pulse; the answer stands one cycle, so read it then
	task automatic access(input logic w, input logic [7:0] c,
		input logic [2:0] q);
		@(negedge mclk);
		acc_valid = 1'b1;
		acc_write = w;
		acc_code = c;
		{acc_bad_size, acc_overflow, acc_unknown} = q;
		@(negedge mclk);
		acc_valid = 1'b0;
		got_valid = rsp_valid;
		got_data = rsp_data;
	endtask

	// Word goes out as two bytes, low byte first
	task automatic load(input logic [7:0] a, input logic [15:0] d);
		for (int i = 0; i < 2; i++) begin
			@(negedge mclk);
			cfg_load_valid = 1'b1;
			cfg_load_addr = a + 8'(i);
			cfg_load_data = d[8*i +: 8];
		end
		@(negedge mclk);
		cfg_load_valid = 1'b0;
	endtask

	// End-of-load verdict pulse
	task automatic verdict(input logic good);
		@(negedge mclk);
		cfg_load_ok = good;
		cfg_load_bad = !good;
		@(negedge mclk);
		cfg_load_ok = 1'b0;
		cfg_load_bad = 1'b0;
	endtask
endmodule

// ### test/tb_battery_status_flag_logic.sv
`timescale 1ns/1ns
module tb_battery_status_flag_logic import gauge_pkg::*;;
	logic mclk = 1'b0, srst = 1'b1;
	logic [15:0] temperature = 16'h0064, max_temperature_limit = 16'h00c8;
	logic [15:0] remaining_capacity_value = 16'h0064;
	logic [15:0] pack_voltage = 16'h4000, cell_voltage = 16'h4000;
	logic [15:0] final_empty_voltage_threshold = 16'h2000;
	logic [15:0] early_empty_voltage_threshold = 16'h3000;
	logic [15:0] capacity_alarm_threshold = 16'h000a;
	logic [15:0] time_alarm_threshold = 16'h000a;
	logic [15:0] runtime_estimate = 16'h0064;
	logic [15:0] averaged_runtime_estimate = 16'h0064;
	logic [15:0] discharge_current = 16'h0000;
	logic [15:0] overload_current_limit = 16'h1000;
	logic [7:0] charge_percentage = 8'h50, battery_low_pct = 8'h0a;
	logic [7:0] activity_filter_setting = 8'h00;
	logic cell_undervoltage_flag = 1'b0, charging = 1'b0;
	logic charge_activity = 1'b0, discharge_activity = 1'b0;
	logic charge_termination = 1'b0, overcharge = 1'b0;
	logic discharged_unit = 1'b0, capacity_mode = 1'b0;
	wire acc_valid, acc_write, acc_bad_size, acc_overflow, acc_unknown;
	wire cfg_load_valid, cfg_load_ok, cfg_load_bad, rsp_valid, cfg_wr_valid;
	wire [7:0] acc_code, cfg_load_addr, cfg_load_data;
	wire [7:0] cfg_wr_addr, cfg_wr_data;
	wire [15:0] rsp_data, status_word, alarm_word;
	int num_errors = 0, check_count = 0;

	// Short second so the silence timer fits the run
	battery_status_flag_logic #(.TICK_CYCLES(20)) u_battery_status_flag_logic (
		.mclk, .srst, .temperature, .max_temperature_limit,
		.remaining_capacity_value, .pack_voltage, .cell_voltage,
		.final_empty_voltage_threshold, .early_empty_voltage_threshold,
		.cell_undervoltage_flag, .capacity_alarm_threshold,
		.time_alarm_threshold, .runtime_estimate, .averaged_runtime_estimate,
		.discharge_current, .overload_current_limit, .charge_percentage,
		.battery_low_pct, .activity_filter_setting, .charging,
		.charge_activity, .discharge_activity, .charge_termination,
		.overcharge, .discharged_unit, .capacity_mode, .cfg_load_valid,
		.cfg_load_addr, .cfg_load_data, .cfg_load_ok, .cfg_load_bad,
		.acc_valid, .acc_write, .acc_code, .acc_bad_size, .acc_overflow,
		.acc_unknown, .rsp_valid, .rsp_data, .status_word, .alarm_word,
		.cfg_wr_valid, .cfg_wr_addr, .cfg_wr_data);
	far_side_model u_far_side_model (.mclk, .rsp_valid, .rsp_data,
		.cfg_wr_valid, .cfg_wr_addr, .cfg_wr_data, .acc_valid, .acc_write,
		.acc_code, .acc_bad_size, .acc_overflow, .acc_unknown,
		.cfg_load_valid, .cfg_load_addr, .cfg_load_data, .cfg_load_ok,
		.cfg_load_bad);

	// -----------------------------
	// Compare and timing helpers
	// -----------------------------
	task automatic chk_bit(input string n, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic chk_word(input string n, input logic [15:0] e,
		input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Two edges of slack keeps the check clear of the update edge
	task automatic flag(input string n, input int b, input logic e);
		step(2);
		chk_bit(n, e, status_word[b]);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		u_far_side_model.access(1'b0, c, 3'b000);
		chk_word("rsp_data", e, u_far_side_model.got_data);
	endtask
	task automatic unit_pulse;
		@(negedge mclk);
		discharged_unit = 1'b1;
		@(negedge mclk);
		discharged_unit = 1'b0;
	endtask
	task automatic end_sim;
		if (num_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// -----------------------------
	// Scenarios
	// -----------------------------
	task automatic t_alarms;
		temperature = 16'h00c8;
		flag("over_temp", BIT_OVER_TEMP, 1'b1);
		chk_word("alarm_word", 16'h100f, alarm_word);
		temperature = 16'h00c7;
		flag("over_temp", BIT_OVER_TEMP, 1'b0);
		for (int i = 0; i < 3; i++) begin
			remaining_capacity_value = (i == 0) ? 16'h0000 : 16'h0064;
			pack_voltage = (i == 1) ? 16'h2000 : 16'h4000;
			cell_undervoltage_flag = (i == 2);
			flag("stop_dis", BIT_STOP_DIS, 1'b1);
			remaining_capacity_value = 16'h0064;
			flag("stop_dis", BIT_STOP_DIS, i != 0);
			pack_voltage = 16'h4000;
			cell_undervoltage_flag = 1'b0;
			flag("stop_dis", BIT_STOP_DIS, 1'b0);
		end
		capacity_alarm_threshold = 16'h0065;
		flag("cap_alarm", BIT_CAP_AL, 1'b1);
		capacity_alarm_threshold = 16'h0064;
		flag("cap_alarm", BIT_CAP_AL, 1'b1);
		remaining_capacity_value = 16'h0063;
		step(1);
		charging = 1'b1;
		remaining_capacity_value = 16'h0064;
		flag("cap_alarm", BIT_CAP_AL, 1'b0);
		charging = 1'b0;
		capacity_alarm_threshold = 16'h0065;
		step(2);
		capacity_alarm_threshold = 16'h0063;
		flag("cap_alarm", BIT_CAP_AL, 1'b0);
		runtime_estimate = 16'h0005;
		averaged_runtime_estimate = 16'h0005;
		flag("time_alarm", BIT_TIME_AL, 1'b1);
		runtime_estimate = 16'h0064;
		flag("time_alarm", BIT_TIME_AL, 1'b1);
		time_alarm_threshold = 16'h0004;
		flag("time_alarm", BIT_TIME_AL, 1'b0);
	endtask

	task automatic t_status;
		u_far_side_model.load(CFG_VOLTAGE, 16'h3a98);
		u_far_side_model.load(CFG_CAP_MAH, 16'h1234);
		u_far_side_model.load(CFG_CAP_MWH, 16'h5678);
		u_far_side_model.load(CFG_FULL_CLR, 16'h0032);
		rd(CMD_VOLTAGE, 16'h3a98);
		rd(CMD_CAPACITY, 16'h1234);
		capacity_mode = 1'b1;
		rd(CMD_CAPACITY, 16'h5678);
		u_far_side_model.verdict(1'b1);
		flag("cfg_valid", BIT_LOADED, 1'b1);
		u_far_side_model.verdict(1'b0);
		flag("cfg_valid", BIT_LOADED, 1'b0);
		charge_termination = 1'b1;
		step(1);
		charge_termination = 1'b0;
		flag("full", BIT_FULL, 1'b1);
		charge_percentage = 8'h33;
		flag("full", BIT_FULL, 1'b1);
		charge_percentage = 8'h32;
		flag("full", BIT_FULL, 1'b0);
		charge_percentage = 8'h50;
		overcharge = 1'b1;
		step(1);
		overcharge = 1'b0;
		flag("full", BIT_FULL, 1'b1);
		charge_percentage = 8'h09;
		flag("empty", BIT_EMPTY, 1'b1);
		charge_percentage = 8'h13;
		flag("empty", BIT_EMPTY, 1'b1);
		charge_percentage = 8'h14;
		flag("empty", BIT_EMPTY, 1'b0);
		cell_voltage = 16'h2fff;
		discharge_current = 16'h1000;
		flag("empty", BIT_EMPTY, 1'b0);
		discharge_current = 16'h0000;
		flag("empty", BIT_EMPTY, 1'b1);
		cell_voltage = 16'h4000;
		flag("empty", BIT_EMPTY, 1'b0);
	endtask

	// Silence timer: 250 per second reaches the window after 90 seconds
	task automatic t_disch;
		discharge_activity = 1'b1;
		step(1);
		discharge_activity = 1'b0;
		flag("disch", BIT_DISCH, 1'b1);
		charging = 1'b1;
		flag("disch", BIT_DISCH, 1'b0);
		charging = 1'b0;
		activity_filter_setting = 8'hfa;
		charge_activity = 1'b1;
		step(1);
		charge_activity = 1'b0;
		step(85 * 20);
		chk_bit("disch", 1'b0, status_word[BIT_DISCH]);
		step(10 * 20);
		chk_bit("disch", 1'b1, status_word[BIT_DISCH]);
		activity_filter_setting = 8'h00;
	endtask

	task automatic t_errors;
		logic [7:0] c [8] = '{8'h24, 8'h23, 8'h1a, 8'h17, 8'h17, 8'h17,
			8'h17, 8'h19};
		logic w [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
		logic [2:0] q [8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h2, 3'h1,
			3'h0};
		logic [3:0] e [8] = '{ERR_RESERVED, ERR_UNSUPPORTED, ERR_UNSUPPORTED,
			ERR_DENIED, ERR_BAD_SIZE, ERR_OVERFLOW, ERR_UNKNOWN, ERR_OK};
		for (int i = 0; i < 8; i++) begin
			u_far_side_model.access(w[i], c[i], q[i]);
			chk_bit("rsp_valid", 1'b1, u_far_side_model.got_valid);
			chk_word("err", {12'h000, e[i]},
				{12'h000, status_word[3:0]});
		end
		u_far_side_model.access(1'b0, 8'h24, 3'b000);
		u_far_side_model.access(1'b0, CMD_STATUS, 3'b000);
		chk_word("old_err", {12'h000, ERR_RESERVED},
			{12'h000, u_far_side_model.got_data[3:0]});
		chk_word("err", {12'h000, ERR_OK}, {12'h000, status_word[3:0]});
	endtask

	task automatic t_cycle;
		u_far_side_model.load(CFG_CYC_THR, 16'h0002);
		u_far_side_model.load(CFG_CYCLE_LO, 16'hfffe);
		rd(CMD_CYCLE, 16'hfffe);
		unit_pulse();
		unit_pulse();
		u_far_side_model.access(1'b0, CMD_CYCLE, 3'b000);
		chk_word("err", {12'h000, ERR_BUSY}, {12'h000, status_word[3:0]});
		step(4);
		chk_word("wb", 16'hffff, {u_far_side_model.mem[CFG_CYCLE_HI],
			u_far_side_model.mem[CFG_CYCLE_LO]});
		repeat (4) unit_pulse();
		step(4);
		rd(CMD_CYCLE, 16'hffff);
	endtask

	initial begin
		forever begin
			#25 mclk = ~mclk;
		end
	end
	initial begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		end_sim();
	end
	initial begin
		step(12);
		chk_word("status_word", 16'h0000, status_word);
		chk_word("alarm_word", 16'h000f, alarm_word);
		srst = 1'b0;
		t_alarms();
		t_status();
		t_disch();
		t_errors();
		t_cycle();
		end_sim();
	end
endmodule
